// [bench/conv_model.sv]
`timescale 1ns/1ps
// ==========================================
// Converter stand-in
module conv_model (
  // Clock, control and the temperature to convert
  input wire logic clk,
  input wire logic conv_active,
  input wire logic [15:0] temp_code,
  // Converter result
  output logic [15:0] sample_code
);
  // Outside a conversion the lines toggle, so a stale sample never looks valid.
  always @(posedge clk) begin
    if (conv_active === 1'b1) begin
      sample_code <= temp_code;
    end else begin
      sample_code <= ~sample_code;
    end
  end
endmodule : conv_model

// [bench/temp_ctrl_tb_top.sv]
`timescale 1ns/1ps
module temp_ctrl_tb_top;
  import temp_pkg::*;
  localparam int CONV_N = 40;
  localparam int FAST_N = 20;
  localparam int IDLE_N = 30;
  localparam int WAKE_N = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [15:0] temp_code = 16'h0C80;
  logic [31:0] readdata, rq, rd;
  logic [15:0] sample_code;
  logic waitrequest, conv_active, limit_alarm_out, critical_alarm_out;
  logic wq, lq, cq, aq;
  int bad_count = 0;
  int num_checks = 0;
  int n, k;
  logic [4:0] ra [6] = '{A_HIGH, A_LOW, A_CRIT, A_HYST, A_CFG, 5'h1C};
  logic [15:0] rv [6] = '{HIGH_RST, LOW_RST, CRIT_RST, {12'h000, HYST_RST}, {8'h00, CFG_RST},
    16'h0000};
  logic [7:0] fc [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
  logic [15:0] fi [4] = '{16'h0C80, 16'hF380, 16'h0C85, 16'hF387};
  logic [15:0] fo [4] = '{16'h0C80, 16'hF381, 16'h0C85, 16'hF387};
  logic [6:0] pat = 7'b1111011;

  always #2.5 clk = ~clk;

  // Outputs are copied mid-cycle so every use sees settled values.
  always @(negedge clk) begin
    wq = waitrequest;
    rq = readdata;
    lq = limit_alarm_out;
    cq = critical_alarm_out;
    aq = conv_active;
  end

  temp_ctrl #(
    .CONV_CYCLES(CONV_N),
    .FAST_CYCLES(FAST_N),
    .IDLE_CYCLES(IDLE_N),
    .WAKE_CYCLES(WAKE_N)
  ) uut (
    .clk(clk),
    .resetn(resetn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .sample_code(sample_code),
    .conv_active(conv_active),
    .limit_alarm_out(limit_alarm_out),
    .critical_alarm_out(critical_alarm_out)
  );

  conv_model partner (
    .clk(clk),
    .conv_active(conv_active),
    .temp_code(temp_code),
    .sample_code(sample_code)
  );

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      t++;
    end while (wq !== 1'b0 && t < 20);
    if (wq !== 1'b0) check("waitrequest", 32'h0, 32'h1);
    rd = rq;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wait_conv();
    int t;
    t = 0;
    do begin
      bus(1'b0, A_STAT, 32'h0);
      t++;
    end while (rd[ST_RDY] !== 1'b1 && t < 60);
    bus(1'b0, A_TEMP, 32'h0);
  endtask : wait_conv

  task automatic run_len(ref logic s, input logic v, input int cap, output int len);
    len = 0;
    while (s === v && len < cap) begin
      @(posedge clk);
      len++;
    end
  endtask : run_len

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ==========================================
  // Tests
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b1, 5'h1C, 32'hFFFF);
    for (k = 0; k < 6; k++) begin
      bus(1'b0, ra[k], 32'h0);
      check("reset value", {16'h0, rv[k]}, rd);
    end
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, A_CFG, {24'h0, fc[k]});
      wait_conv();
      temp_code <= fi[k];
      wait_conv();
      check("temp format", {16'h0, fo[k]}, rd);
      check("temp 9-bit", {23'h0, fo[k][15:7]}, {23'h0, rd[15:7]});
    end
    $display("test formats done");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, A_CFG, 32'(k));
      temp_code <= 16'h0C80;
      wait_conv();
      check("limit in band", 32'h0, {31'h0, lq});
      temp_code <= 16'h2300;
      for (n = 1; n <= k + 1; n++) begin
        wait_conv();
        check("fault queue", 32'(n == k + 1), {31'h0, lq});
      end
    end
    temp_code <= 16'h0C80;
    wait_conv();
    for (n = 0; n < 7; n++) begin
      temp_code <= pat[n] ? 16'h2300 : 16'h0C80;
      wait_conv();
      check("fault restart", 32'(n == 6), {31'h0, lq});
    end
    $display("test fault queue done");
    bus(1'b1, A_CFG, 32'h10);
    temp_code <= 16'h4B00;
    run_len(cq, 1'b0, 200, n);
    check("alarms set", 32'h3, {30'h0, lq, cq});
    bus(1'b0, A_HIGH, 32'h0);
    check("alarms after read", 32'h0, {30'h0, lq, cq});
    $display("test interrupt mode done");
    bus(1'b1, A_CFG, 32'h00);
    temp_code <= 16'h0C80;
    wait_conv();
    wait_conv();
    temp_code <= 16'h4B00;
    bus(1'b1, A_CFG, 32'h20);
    run_len(cq, 1'b0, 200, n);
    check("one-shot delay", 32'h1, 32'(n >= CONV_N - 4 && n <= CONV_N + 1));
    repeat (2) @(posedge clk);
    run_len(aq, 1'b0, 60, n);
    check("one-shot stops", 32'd60, 32'(n));
    check("alarms held", 32'h3, {30'h0, lq, cq});
    temp_code <= 16'h0C80;
    // Raised limits put the held result inside the band, so only the mode write can clear.
    bus(1'b1, A_HIGH, 32'h7D00);
    bus(1'b1, A_CRIT, 32'h7D00);
    bus(1'b1, A_CFG, 32'h20);
    check("one-shot write clear", 32'h0, {30'h0, lq, cq});
    bus(1'b1, A_HIGH, {16'h0, HIGH_RST});
    bus(1'b1, A_CRIT, {16'h0, CRIT_RST});
    repeat (CONV_N + 4) @(posedge clk);
    check("one-shot clear", 32'h0, {30'h0, lq, cq});
    $display("test one-shot done");
    bus(1'b1, A_CFG, 32'h60);
    temp_code <= 16'h2300;
    run_len(aq, 1'b0, 100, n);
    check("shutdown idle", 32'd100, 32'(n));
    bus(1'b0, A_TEMP, 32'h0);
    check("kept result", 32'h0C80, rd);
    bus(1'b1, A_CFG, 32'h00);
    run_len(aq, 1'b0, 100, n);
    check("wake time", 32'h1, 32'(n >= WAKE_N - 3 && n <= WAKE_N + 1));
    wait_conv();
    check("first after wake", 32'h2302, rd);
    $display("test shutdown done");
    bus(1'b1, A_CFG, 32'h40);
    run_len(aq, 1'b1, 100, n);
    run_len(aq, 1'b0, 100, n);
    check("idle span", 32'h1, 32'(n >= IDLE_N - 1 && n <= IDLE_N + 1));
    run_len(aq, 1'b1, 100, n);
    check("conv span", 32'h1, 32'(n >= FAST_N - 1 && n <= FAST_N + 1));
    $display("test one per second done");
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : temp_ctrl_tb_top

// [common/temp_pkg.sv]
package temp_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int CONV_MS = 240;
  localparam int FAST_MS = 60;
  localparam int IDLE_MS = 940;
  localparam int WAKE_MS = 1;
  localparam int CONV_CYC = CONV_MS * CLK_KHZ;
  localparam int FAST_CYC = FAST_MS * CLK_KHZ;
  localparam int IDLE_CYC = IDLE_MS * CLK_KHZ;
  localparam int WAKE_CYC = WAKE_MS * CLK_KHZ;
  localparam int TMR_W = 32;
  // ==========================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_TEMP = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_CFG = 5'h08;
  localparam logic [4:0] A_HIGH = 5'h0C;
  localparam logic [4:0] A_LOW = 5'h10;
  localparam logic [4:0] A_CRIT = 5'h14;
  localparam logic [4:0] A_HYST = 5'h18;
  // ==========================================================
  // Fields and reset values
  localparam int CFG_INT = 4;
  localparam int CFG_RES = 7;
  localparam int ST_RDY = 0;
  localparam int ST_LIM = 1;
  localparam int ST_CRT = 2;
  localparam int ST_BSY = 3;
  localparam int FLAG_W = 3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] HIGH_RST = 16'h2000;
  localparam logic [15:0] LOW_RST = 16'h0500;
  localparam logic [15:0] CRIT_RST = 16'h4980;
  localparam logic [3:0] HYST_RST = 4'h5;
  localparam logic [3:0] FRAC_ZERO = 4'h0;
  localparam logic [5:0] HYST_PAD = 6'h00;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_NORMAL, MODE_ONESHOT, MODE_SPS, MODE_SHUT} mode_t;
  typedef enum logic [1:0] {ST_WAKE, ST_CONV, ST_IDLE, ST_SHUT} state_t;
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
    logic [15:0] crit;
    logic [3:0] hyst;
  } limits_t;
  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } flags_t;
endpackage : temp_pkg

// [src/temp_ctrl.sv]
`timescale 1ns/1ps
module temp_ctrl
  import temp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int FAST_CYCLES = FAST_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [temp_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Converter
  input wire logic [15:0] sample_code,
  output logic conv_active,
  // Alarms
  output logic limit_alarm_out,
  output logic critical_alarm_out
);
  import temp_pkg::*;

  // ==========================================================
  // Bus handshake
  logic ack_r;
  logic [31:0] rdata_r;
  wire req = read | write;
  wire wr_fire = write & ack_r;
  wire rd_fire = read & ack_r;
  wire [31:0] rd_mux;
  assign waitrequest = req & ~ack_r;
  assign readdata = rdata_r;

  // ==========================================================
  // Registers
  logic [7:0] cfg_r;
  limits_t lim_r;
  logic [15:0] temp_r;
  logic [2:0] fault_r;
  logic lim_al_r;
  logic crit_al_r;
  logic rdy_r;
  state_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;

  wire cfg_wr = wr_fire && address == A_CFG && byteenable[0];
  wire mode_t mode_new = mode_t'(writedata[6:5]);
  wire mode_t mode_cur = mode_t'(cfg_r[6:5]);
  wire res16 = cfg_r[CFG_RES];
  wire int_mode = cfg_r[CFG_INT];
  wire [1:0] need = cfg_r[1:0];
  wire conv_end = st_r == ST_CONV && tmr_r == '0;
  wire temp_rd = rd_fire && address == A_TEMP;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [TMR_W-1:0] len_of(input mode_t m);
    len_of = (m == MODE_SPS) ? TMR_W'(FAST_CYCLES - 1) : TMR_W'(CONV_CYCLES - 1);
  endfunction : len_of

  // ==========================================================
  // Comparison on the 13-bit signed field
  wire signed [13:0] t_new = $signed({sample_code[15], sample_code[15:3]});
  wire signed [13:0] t_old = $signed({temp_r[15], temp_r[15:3]});
  wire signed [13:0] lim_hi = $signed({lim_r.high[15], lim_r.high[15:3]});
  wire signed [13:0] lim_lo = $signed({lim_r.low[15], lim_r.low[15:3]});
  wire signed [13:0] lim_cr = $signed({lim_r.crit[15], lim_r.crit[15:3]});
  wire signed [13:0] hy = $signed({HYST_PAD, lim_r.hyst, FRAC_ZERO});
  flags_t fl;
  assign fl.crit = t_new > lim_cr;
  assign fl.high = t_new > lim_hi;
  assign fl.low = t_new < lim_lo;
  wire fault_now = fl.crit | fl.high | fl.low;
  wire band_new = t_new < lim_hi - hy && t_new > lim_lo + hy;
  wire band_old = t_old < lim_hi - hy && t_old > lim_lo + hy;
  wire below_cr_new = t_new < lim_cr - hy;
  wire below_cr_old = t_old < lim_cr - hy;

  // ==========================================================
  // Fault queue
  wire trip = fault_now && fault_r >= {1'b0, need};
  wire mode_chg = cfg_wr && (mode_new != mode_cur || st_r == ST_SHUT);
  wire [2:0] fault_nxt =
      mode_chg ? 3'h0 :
      !conv_end ? fault_r :
      !fault_now ? 3'h0 :
      (fault_r > {1'b0, need}) ? fault_r : fault_r + 3'h1;

  // ==========================================================
  // Alarm outputs
  wire lim_set = conv_end && trip && (fl.high | fl.low);
  wire crit_set = conv_end && trip && fl.crit;
  wire os_cmp_wr = cfg_wr && !int_mode && mode_cur == MODE_ONESHOT;
  wire lim_clr = int_mode ? rd_fire :
      (conv_end && band_new) || (os_cmp_wr && band_old);
  wire crit_clr = int_mode ? rd_fire :
      (conv_end && below_cr_new) ||
      (os_cmp_wr && mode_new == MODE_ONESHOT && below_cr_old);
  wire lim_nxt = lim_set | (lim_al_r & ~lim_clr);
  wire crit_nxt = crit_set | (crit_al_r & ~crit_clr);

  // Ready flag: conversion end wins over a clearing access.
  wire rdy_clr = temp_rd || (cfg_wr && (mode_new == MODE_ONESHOT || mode_new == MODE_SPS));
  wire rdy_nxt = conv_end | (rdy_r & ~rdy_clr);

  wire [15:0] result = res16 ? sample_code : {sample_code[15:3], fl};

  // ==========================================================
  // Operating mode sequencer
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r - TMR_W'(1);
    if (cfg_wr) begin
      case (mode_new)
        MODE_SHUT: begin
          st_nxt = ST_SHUT;
          tmr_nxt = '0;
        end
        MODE_NORMAL: begin
          if (st_r == ST_SHUT) begin
            st_nxt = ST_WAKE;
            tmr_nxt = TMR_W'(WAKE_CYCLES - 1);
          end else if (st_r != ST_CONV) begin
            st_nxt = ST_CONV;
            tmr_nxt = len_of(MODE_NORMAL);
          end
        end
        default: begin
          st_nxt = ST_CONV;
          tmr_nxt = len_of(mode_new);
        end
      endcase
    end else begin
      case (st_r)
        ST_WAKE: begin
          if (tmr_r == '0) begin
            st_nxt = ST_CONV;
            tmr_nxt = len_of(MODE_NORMAL);
          end
        end
        ST_CONV: begin
          if (tmr_r == '0) begin
            case (mode_cur)
              MODE_ONESHOT: begin
                st_nxt = ST_SHUT;
                tmr_nxt = '0;
              end
              MODE_SPS: begin
                st_nxt = ST_IDLE;
                tmr_nxt = TMR_W'(IDLE_CYCLES - 1);
              end
              MODE_SHUT: begin
                st_nxt = ST_SHUT;
                tmr_nxt = '0;
              end
              default: tmr_nxt = len_of(MODE_NORMAL);
            endcase
          end
        end
        ST_IDLE: begin
          if (tmr_r == '0) begin
            st_nxt = ST_CONV;
            tmr_nxt = len_of(MODE_SPS);
          end
        end
        default: tmr_nxt = tmr_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_CONV;
      tmr_r <= TMR_W'(CONV_CYCLES - 1);
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // ==========================================================
  // Result, queue, alarms
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_r <= '0;
      fault_r <= '0;
      lim_al_r <= 1'b0;
      crit_al_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      if (conv_end) temp_r <= result;
      fault_r <= fault_nxt;
      lim_al_r <= lim_nxt;
      crit_al_r <= crit_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // ==========================================================
  // Register file
  assign rd_mux =
      (address == A_TEMP) ? {16'h0000, temp_r} :
      (address == A_STAT) ? {28'h0000000, st_r == ST_CONV, crit_al_r, lim_al_r, rdy_r} :
      (address == A_CFG) ? {24'h000000, cfg_r} :
      (address == A_HIGH) ? {16'h0000, lim_r.high} :
      (address == A_LOW) ? {16'h0000, lim_r.low} :
      (address == A_CRIT) ? {16'h0000, lim_r.crit} :
      (address == A_HYST) ? {28'h0000000, lim_r.hyst} : 32'h00000000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
      cfg_r <= CFG_RST;
      lim_r <= '{HIGH_RST, LOW_RST, CRIT_RST, HYST_RST};
    end else begin
      ack_r <= req & ~ack_r;
      if (read && !ack_r) rdata_r <= rd_mux;
      if (cfg_wr) cfg_r <= writedata[7:0];
      if (wr_fire && address == A_HIGH) lim_r.high <= merge16(lim_r.high, writedata, byteenable);
      if (wr_fire && address == A_LOW) lim_r.low <= merge16(lim_r.low, writedata, byteenable);
      if (wr_fire && address == A_CRIT) lim_r.crit <= merge16(lim_r.crit, writedata, byteenable);
      if (wr_fire && address == A_HYST && byteenable[0]) lim_r.hyst <= writedata[3:0];
    end
  end

  assign conv_active = st_r == ST_CONV;
  assign limit_alarm_out = lim_al_r;
  assign critical_alarm_out = crit_al_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_end_quiet;
    conv_end && !cfg_wr;
  endsequence

  int_read_clear_a: assert property (
    rd_fire && int_mode && !lim_set && !crit_set |=> !lim_al_r && !crit_al_r)
    else $error("alarm survived a read in interrupt mode");
  shut_stays_a: assert property (
    st_r == ST_SHUT && !cfg_wr |=> st_r == ST_SHUT && !conv_active)
    else $error("conversion started in shutdown");
  wake_path_a: assert property (
    cfg_wr && mode_new == MODE_NORMAL && st_r == ST_SHUT |=>
      st_r == ST_WAKE && tmr_r == TMR_W'(WAKE_CYCLES - 1))
    else $error("wake from shutdown not started");
  result_kept_a: assert property (
    st_r == ST_SHUT |=> $stable(temp_r))
    else $error("result changed in shutdown");
  fault_reset_a: assert property (
    s_end_quiet ##0 !fault_now |=> fault_r == 3'h0)
    else $error("fault counter not cleared");
  crit_at_end_a: assert property (
    $rose(crit_al_r) |-> $past(conv_end) && $past(fault_r) >= {1'b0, $past(need)})
    else $error("critical alarm rose outside a tripping conversion end");
  flag_bits_a: assert property (
    conv_end && !res16 |=> temp_r[2:0] == $past(fl) && temp_r[15:3] == $past(sample_code[15:3]))
    else $error("13-bit result format wrong");
  full_res_a: assert property (
    conv_end && res16 |=> temp_r == $past(sample_code))
    else $error("16-bit result wrong");
  sps_idle_a: assert property (
    s_end_quiet ##0 mode_cur == MODE_SPS |=>
      st_r == ST_IDLE && tmr_r == TMR_W'(IDLE_CYCLES - 1))
    else $error("1 SPS idle not entered");
  oneshot_end_a: assert property (
    s_end_quiet ##0 mode_cur == MODE_ONESHOT |=> st_r == ST_SHUT)
    else $error("one-shot did not shut down");
  normal_rerun_a: assert property (
    s_end_quiet ##0 mode_cur == MODE_NORMAL |=>
      st_r == ST_CONV && tmr_r == TMR_W'(CONV_CYCLES - 1))
    else $error("normal mode did not restart conversion");
  bus_answer_a: assert property (
    req && waitrequest |=> !waitrequest)
    else $error("waitrequest held beyond one cycle");
endmodule : temp_ctrl
